// ---- dmxk_cfg.svh ----
// constants of the demux keying and timing chain
// assumes inclusion by bare name from the package and the modules
`ifndef DMXK_CFG_SVH
`define DMXK_CFG_SVH
`define DMXK_CHANNELS 8
`define DMXK_SEQ_STAGES 7
`define DMXK_DIV_STAGES 3
`define DMXK_RATIO_DIV2 2'h1
`define DMXK_RATIO_DIV4 2'h2
`define DMXK_RATIO_DIV8 2'h3
`define DMXK_GA_RATIO 2'h2
`define DMXK_SUBCOM_SRC_CH 0
`define DMXK_GATE_COMMON_A 2
`define DMXK_GATE_COMMON_B 3
`define DMXK_SEQ_RST 7'h00
`define DMXK_DIV_RST 3'h0
`endif

// ---- dmxk_chain.sv ----
// keying and timing chain: pulse set, divider, three sequencers,
// keying matrix and eight data gates
// assumes clock square wave and frame sync arrive asynchronously on pins
//
// Operation
// - divide by two, four, eight via three stages
// - each stage has own set and reset
// - second telemetry mode forces divide by four
// - frame sync reset clears stages in use
// - eight sequential channels, seven stages, eight gates
// - each trigger steps to next channel
// - reset pulse picks the active channel
// - matrix ands eight distinct sequencer pairs
// - matrix key only while both inputs high
// - eight two-input data and gates
// - gates one-four, five-eight share common inputs
// - first and eighth gate keys go outside
// - gate passes video when keyed, else zero
// - three inputs give three trigger trains
// - clock rise gives delayed data sync trigger
// - only clock path carries the delay
// - divider output rise triggers low-speed sequencer
// - subcom pulse rise triggers subcom sequencer
`timescale 1ns/10ps
`include "dmxk_cfg.svh"
module dmxk_chain #(
    parameter int VW = 12,
    parameter int DW = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_sq_pin,
    input wire logic frame_sync_pin,
    input wire logic [`DMXK_DIV_STAGES-1:0] div_set_pin,
    input wire logic [`DMXK_DIV_STAGES-1:0] div_reset_pin,
    input wire logic ga_mode,
    input wire logic [1:0] div_ratio,
    input wire logic [DW-1:0] dsync_delay,
    input wire logic [2:0] main_phase_ch,
    input wire logic [2:0] low_phase_ch,
    input wire logic [2:0] subcom_phase_ch,
    input wire logic [VW-1:0] video_in,
    output logic data_sync_trig,
    output logic low_trig,
    output logic subcom_trig,
    output logic [`DMXK_DIV_STAGES-1:0] div_out,
    output logic [`DMXK_CHANNELS-1:0] sh_key,
    output logic key_first,
    output logic key_last,
    output logic [`DMXK_CHANNELS-1:0][VW-1:0] gated_video
);
    typedef struct packed {
        logic clk_meta;
        logic clk_sync;
        logic clk_prev;
        logic fs_meta;
        logic fs_sync;
        logic fs_prev;
        logic [`DMXK_DIV_STAGES-1:0] set_meta;
        logic [`DMXK_DIV_STAGES-1:0] set_sync;
        logic [`DMXK_DIV_STAGES-1:0] clr_meta;
        logic [`DMXK_DIV_STAGES-1:0] clr_sync;
        logic [`DMXK_DIV_STAGES-1:0] div;
        logic sel_prev;
        logic sub_prev;
        logic [DW-1:0] dly_cnt;
        logic dly_pend;
        logic dsync;
        logic low;
        logic sub;
        logic [`DMXK_CHANNELS-1:0] key;
        logic [`DMXK_CHANNELS-1:0] gate;
        logic [`DMXK_CHANNELS-1:0][VW-1:0] video;
    } dmxk_core_t;

    dmxk_core_t s;
    dmxk_core_t next_s;
    logic clk_rise;
    logic fs_pulse;
    dmxk_pkg::dmxk_ratio_t ratio;
    logic [`DMXK_DIV_STAGES-1:0] in_use;
    logic [1:0] sel_idx;
    logic sel_out;
    logic sub_src;
    logic carry;
    logic common_a;
    logic common_b;
    dmxk_pkg::dmxk_chan_t main_chan;
    dmxk_pkg::dmxk_chan_t low_chan;
    dmxk_pkg::dmxk_chan_t sub_chan;

    // edges are taken only from the second synchroniser stage
    assign clk_rise = s.clk_sync & ~s.clk_prev;
    assign fs_pulse = s.fs_sync & ~s.fs_prev;

    always_comb
    begin
        if (ga_mode)
        begin
            ratio = `DMXK_GA_RATIO;
        end
        else if (div_ratio == 2'h0)
        begin
            ratio = `DMXK_RATIO_DIV2;
        end
        else
        begin
            ratio = div_ratio;
        end
    end

    always_comb
    begin
        case (ratio)
            `DMXK_RATIO_DIV2: in_use = 3'h1;
            `DMXK_RATIO_DIV4: in_use = 3'h3;
            `DMXK_RATIO_DIV8: in_use = 3'h7;
            default: in_use = 3'h1;
        endcase
    end

    assign sel_idx = ratio - 2'h1;
    assign sel_out = s.div[sel_idx];
    assign sub_src = low_chan[`DMXK_SUBCOM_SRC_CH];
    assign common_a = low_chan[`DMXK_GATE_COMMON_A];
    assign common_b = low_chan[`DMXK_GATE_COMMON_B];

    always_comb
    begin
        next_s = s;
        carry = clk_rise;
        // synchronisers
        next_s.clk_meta = clk_sq_pin;
        next_s.clk_sync = s.clk_meta;
        next_s.clk_prev = s.clk_sync;
        next_s.fs_meta = frame_sync_pin;
        next_s.fs_sync = s.fs_meta;
        next_s.fs_prev = s.fs_sync;
        next_s.set_meta = div_set_pin;
        next_s.set_sync = s.set_meta;
        next_s.clr_meta = div_reset_pin;
        next_s.clr_sync = s.clr_meta;
        // ripple stages made synchronous: a stage toggles when all below are high
        for (int i = 0; i < `DMXK_DIV_STAGES; i++)
        begin
            next_s.div[i] = s.div[i] ^ carry;
            carry = carry & s.div[i];
        end
        if (fs_pulse)
        begin
            next_s.div = next_s.div & ~in_use;
        end
        // pin reset wins over pin set on the same stage
        next_s.div = (next_s.div | s.set_sync) & ~s.clr_sync;
        // undelayed trigger trains from divider and subcom pulses
        next_s.sel_prev = sel_out;
        next_s.low = sel_out & ~s.sel_prev;
        next_s.sub_prev = sub_src;
        next_s.sub = sub_src & ~s.sub_prev;
        // delayed data sync: a new clock rise restarts a pending delay
        next_s.dsync = 1'b0;
        if (clk_rise)
        begin
            next_s.dly_cnt = dsync_delay;
            next_s.dly_pend = 1'b1;
        end
        else if (s.dly_cnt != '0)
        begin
            next_s.dly_cnt = s.dly_cnt - DW'(1);
        end
        else if (s.dly_pend)
        begin
            next_s.dly_pend = 1'b0;
            next_s.dsync = 1'b1;
        end
        // keying matrix
        next_s.key = main_chan & low_chan;
        // data gate and gates with two common inputs
        for (int i = 0; i < `DMXK_CHANNELS; i++)
        begin
            if (i < `DMXK_CHANNELS / 2)
            begin
                next_s.gate[i] = sub_chan[i] & common_a;
            end
            else
            begin
                next_s.gate[i] = sub_chan[i] & common_b;
            end
            if (next_s.gate[i])
            begin
                next_s.video[i] = video_in;
            end
            else
            begin
                next_s.video[i] = '0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.div <= `DMXK_DIV_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // main sequencer steps on delayed data sync, others on their trains
    dmxk_seq u_main_seq (
        .core_clk(core_clk),
        .rst(rst),
        .trig(s.dsync),
        .phase_reset(fs_pulse),
        .phase_ch(main_phase_ch),
        .chan(main_chan)
    );

    dmxk_seq u_low_seq (
        .core_clk(core_clk),
        .rst(rst),
        .trig(s.low),
        .phase_reset(fs_pulse),
        .phase_ch(low_phase_ch),
        .chan(low_chan)
    );

    dmxk_seq u_sub_seq (
        .core_clk(core_clk),
        .rst(rst),
        .trig(s.sub),
        .phase_reset(fs_pulse),
        .phase_ch(subcom_phase_ch),
        .chan(sub_chan)
    );

    assign data_sync_trig = s.dsync;
    assign low_trig = s.low;
    assign subcom_trig = s.sub;
    assign div_out = s.div;
    assign sh_key = s.key;
    assign key_first = s.gate[0];
    assign key_last = s.gate[`DMXK_CHANNELS-1];
    assign gated_video = s.video;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_div_first: assert property (clk_rise && !fs_pulse && s.set_sync == '0 &&
        s.clr_sync == '0 |=> s.div[0] != $past(s.div[0]))
        else $error("first divider stage did not toggle");
    a_div_carry: assert property (s.set_sync == '0 && s.clr_sync == '0 && !fs_pulse
        |=> s.div[1] == ($past(s.div[1]) ^ ($past(clk_rise) & $past(s.div[0]))))
        else $error("second divider stage carry wrong");
    a_div_pins: assert property (s.clr_sync[2] |=> !s.div[2])
        else $error("pin reset did not clear stage");
    a_ga_ratio: assert property (ga_mode |-> ratio == `DMXK_GA_RATIO && in_use == 3'h3)
        else $error("second mode not dividing by four");
    a_fs_clear: assert property (fs_pulse && s.set_sync == '0 |=>
        (s.div & $past(in_use)) == '0)
        else $error("frame sync did not clear stages in use");
    a_low_trig: assert property ((sel_out && !s.sel_prev) |=> s.low ##1 !s.low)
        else $error("low-speed trigger missing or long");
    a_sub_trig: assert property (!(sub_src && !s.sub_prev) |=> !s.sub)
        else $error("subcom trigger without rising pulse");
    a_dsync_time: assert property (clk_rise && dsync_delay == 2 ##1 !clk_rise[*3]
        |=> s.dsync)
        else $error("data sync trigger not at loaded delay");
    a_dsync_load: assert property (clk_rise |=> s.dly_pend && !s.dsync &&
        s.dly_cnt == $past(dsync_delay))
        else $error("delay counter not reloaded on clock rise");
    a_pulse_width: assert property (s.dsync |=> !s.dsync)
        else $error("data sync trigger longer than one cycle");
    a_key_and: assert property (1'b1 |=> s.key == ($past(main_chan) & $past(low_chan)))
        else $error("matrix key not and of its pair");
    a_gate_common: assert property (1'b1 |=>
        s.gate[7:4] == ($past(sub_chan[7:4]) & {4{$past(common_b)}}))
        else $error("upper data gates ignore common input");
    a_gate_video: assert property (s.gate[0] |-> s.video[0] == $past(video_in))
        else $error("keyed gate did not pass video");

    c_dsync: cover property (clk_rise ##[1:20] s.dsync);
    c_low: cover property (s.low ##[1:200] s.sub);
    c_key: cover property (|s.key);
    c_gate_last: cover property (key_last);
endmodule : dmxk_chain

// ---- dmxk_pkg.sv ----
// types and decode helpers shared by the sequencer and the chain
// assumes dmxk_cfg.svh is on the include path
`include "dmxk_cfg.svh"
package dmxk_pkg;
    typedef logic [`DMXK_SEQ_STAGES-1:0] dmxk_stages_t;
    typedef logic [`DMXK_CHANNELS-1:0] dmxk_chan_t;
    typedef logic [1:0] dmxk_ratio_t;
    typedef struct packed {
        dmxk_stages_t stages;
    } dmxk_seq_state_t;

    // thermometer fill of k low stages selects channel k
    function automatic dmxk_stages_t dmxk_therm(input logic [2:0] k);
        dmxk_stages_t t;
        t = '0;
        for (int i = 0; i < `DMXK_SEQ_STAGES; i++)
        begin
            t[i] = (3'(i) < k);
        end
        return t;
    endfunction : dmxk_therm

    // six two-input and gates over the seven stages, plus an inverted first-stage tap and a direct last-stage tap
    function automatic dmxk_chan_t dmxk_decode(input dmxk_stages_t s);
        dmxk_chan_t c;
        c = '0;
        c[0] = ~s[0];
        for (int i = 1; i < `DMXK_SEQ_STAGES; i++)
        begin
            c[i] = s[i-1] & ~s[i];
        end
        c[`DMXK_CHANNELS-1] = s[`DMXK_SEQ_STAGES-1];
        return c;
    endfunction : dmxk_decode
endpackage : dmxk_pkg

// ---- dmxk_seq.sv ----
// eight-channel pulse sequencer: seven stages, eight decode gates
// assumes one-cycle trigger and phase reset pulses on core_clk
`timescale 1ns/10ps
`include "dmxk_cfg.svh"
module dmxk_seq (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic trig,
    input wire logic phase_reset,
    input wire logic [2:0] phase_ch,
    output logic [`DMXK_CHANNELS-1:0] chan
);
    dmxk_pkg::dmxk_seq_state_t s;
    dmxk_pkg::dmxk_seq_state_t next_s;

    always_comb
    begin
        next_s = s;
        if (phase_reset)
        begin
            next_s.stages = dmxk_pkg::dmxk_therm(phase_ch);
        end
        else if (trig)
        begin
            // last channel wraps by emptying the thermometer
            if (s.stages[`DMXK_SEQ_STAGES-1])
            begin
                next_s.stages = '0;
            end
            else
            begin
                next_s.stages = {s.stages[`DMXK_SEQ_STAGES-2:0], 1'b1};
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s.stages <= `DMXK_SEQ_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign chan = dmxk_pkg::dmxk_decode(s.stages);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_seq_onehot: assert property ($onehot(chan))
        else $error("sequencer channels not one-hot");
    a_seq_advance: assert property (trig && !phase_reset |=>
        chan == {$past(chan[6:0]), $past(chan[7])})
        else $error("sequencer did not step to next channel");
    a_seq_idle: assert property (!trig && !phase_reset |=> $stable(chan))
        else $error("sequencer moved without trigger");
    a_seq_phase: assert property (phase_reset |=> chan == (8'h01 << $past(phase_ch)))
        else $error("phase reset chose wrong channel");
endmodule : dmxk_seq

// ---- dmxk_sh_bank.sv ----
// sample-and-hold bank fed by the matrix keys and the gated video lanes
// assumes keys and lanes are registered on core_clk
`timescale 1ns/10ps
`include "dmxk_cfg.svh"
module dmxk_sh_bank #(
    parameter int VW = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`DMXK_CHANNELS-1:0] sh_key,
    input wire logic [`DMXK_CHANNELS-1:0][VW-1:0] gated_video,
    output logic [`DMXK_CHANNELS-1:0][VW-1:0] held
);
    // memory state between keys; a key while the gate is shut stores zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            held <= '0;
        end
        else
        begin
            for (int i = 0; i < `DMXK_CHANNELS; i++)
            begin
                if (sh_key[i])
                begin
                    held[i] <= gated_video[i];
                end
            end
        end
    end
endmodule : dmxk_sh_bank

// ---- tb.sv ----
// self-checking bench: cycle model of the keying chain compared every cycle
// assumes the chain and the sample-and-hold bank compile before it
`timescale 1ns/10ps
`include "dmxk_cfg.svh"
module tb;
    localparam int VW = 12;
    localparam int DW = 12;
    logic core_clk, rst, clk_sq_pin, frame_sync_pin, ga_mode;
    logic [2:0] div_set_pin, div_reset_pin, main_phase_ch, low_phase_ch, subcom_phase_ch, div_out;
    logic [1:0] div_ratio;
    logic [DW-1:0] dsync_delay;
    logic [VW-1:0] video_in;
    logic data_sync_trig, low_trig, subcom_trig, key_first, key_last;
    logic [7:0] sh_key, mk, mg;
    logic [7:0][VW-1:0] gated_video, held, mv;
    int num_errors, compares, cnt, mch, lch, sch, sel;
    logic cs1, cs2, cs3, ckr, fs1, fs2, fs3, fsp, arm, trg, lt, st, nst, lc0p, g;
    logic [2:0] dv, dvp, vs1, vs2, vr1, vr2;

    dmxk_chain #(.VW(VW), .DW(DW)) dmxk_chain_inst (.core_clk(core_clk), .rst(rst),
        .clk_sq_pin(clk_sq_pin), .frame_sync_pin(frame_sync_pin), .div_set_pin(div_set_pin),
        .div_reset_pin(div_reset_pin), .ga_mode(ga_mode), .div_ratio(div_ratio),
        .dsync_delay(dsync_delay), .main_phase_ch(main_phase_ch), .low_phase_ch(low_phase_ch),
        .subcom_phase_ch(subcom_phase_ch), .video_in(video_in),
        .data_sync_trig(data_sync_trig), .low_trig(low_trig), .subcom_trig(subcom_trig),
        .div_out(div_out), .sh_key(sh_key), .key_first(key_first), .key_last(key_last),
        .gated_video(gated_video));
    dmxk_sh_bank #(.VW(VW)) dmxk_sh_bank_inst (.core_clk(core_clk), .rst(rst),
        .sh_key(sh_key), .gated_video(gated_video), .held(held));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        video_in <= VW'($urandom);
    end

    // reference model; blocking order keeps every read on the old state
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            {cs1, cs2, cs3, ckr, fs1, fs2, fs3, fsp, arm, trg, lt, st, lc0p} = '0;
            {dv, dvp, vs1, vs2, vr1, vr2, mk, mg} = '0;
            mv = '0;
            {cnt, mch, lch, sch} = '0;
        end
        else
        begin
            // edge detects see the old synchroniser state, as the design's do
            ckr = cs2 && !cs3;
            fsp = fs2 && !fs3;
            for (int i = 0; i < 8; i++)
            begin
                g = ((i < 4) ? lch == 2 : lch == 3) && sch == i;
                mg[i] = g;
                mv[i] = g ? video_in : '0;
                mk[i] = (mch == i) && (lch == i);
            end
            nst = (lch == 0) && !lc0p;
            lc0p = (lch == 0);
            mch = fsp ? int'(main_phase_ch) : (trg ? (mch + 1) % 8 : mch);
            lch = fsp ? int'(low_phase_ch) : (lt ? (lch + 1) % 8 : lch);
            sch = fsp ? int'(subcom_phase_ch) : (st ? (sch + 1) % 8 : sch);
            st = nst;
            sel = ga_mode ? 1 : ((div_ratio == 2'h0) ? 0 : int'(div_ratio) - 1);
            lt = dv[sel] && !dvp[sel];
            dvp = dv;
            // a clock rise in the firing cycle restarts the count and loses the pulse
            trg = arm && cnt == 0 && !ckr;
            if (ckr)
            begin
                cnt = int'(dsync_delay);
                arm = 1'b1;
            end
            else if (arm)
            begin
                if (cnt == 0)
                    arm = 1'b0;
                else
                    cnt--;
            end
            if (ckr)
                dv = {dv[2] ^ (dv[1] & dv[0]), dv[1] ^ dv[0], ~dv[0]};
            if (fsp)
                dv = dv & ~3'((1 << (sel + 1)) - 1);
            dv = (dv | vs2) & ~vr2;
            {vs2, vs1, vr2, vr1} = {vs1, div_set_pin, vr1, div_reset_pin};
            {cs3, cs2, cs1} = {cs2, cs1, clk_sq_pin};
            {fs3, fs2, fs1} = {fs2, fs1, frame_sync_pin};
        end
    end

    always @(negedge core_clk)
    begin
        compares += 3;
        if ({data_sync_trig, low_trig, subcom_trig, div_out} !== {trg, lt, st, dv})
            bad("trigger or divider mismatch");
        if (sh_key !== mk)
            bad("matrix key mismatch");
        if ({key_first, key_last, gated_video} !== {mg[0], mg[7], mv})
            bad("data gate mismatch");
    end

    task automatic bad(input string msg);
        num_errors++;
        $display("BAD at %0t: %s", $time, msg);
    endtask : bad

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // n square wave periods of half width h, frame sync rising at period fp
    task automatic sq(input int h, input int n, input int fp);
        for (int p = 0; p < n; p++)
        begin
            clk_sq_pin <= 1'b1;
            cyc(h);
            clk_sq_pin <= 1'b0;
            frame_sync_pin <= (p == fp);
            cyc(h);
        end
    endtask : sq

    task automatic restart;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
    endtask : restart

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        #600000;
        bad("watchdog expired");
        complete_run();
    end

    initial
    begin
        {rst, clk_sq_pin, frame_sync_pin, ga_mode} = 4'h8;
        {div_set_pin, div_reset_pin, main_phase_ch, low_phase_ch, subcom_phase_ch} = '0;
        {div_ratio, dsync_delay, video_in} = '0;
        {num_errors, compares} = '0;
        void'($urandom(16411));
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        // every ratio code, then the forced mode; frame sync lands in period five to ten of eighty
        for (int t = 0; t < 6; t++)
        begin
            restart();
            div_ratio <= 2'(t);
            ga_mode <= (t > 3);
            dsync_delay <= DW'($urandom_range(0, 5));
            {main_phase_ch, low_phase_ch, subcom_phase_ch} <= 9'($urandom);
            cyc(1);
            sq(int'(dsync_delay) / 2 + 3, 80, 5 + t);
            $display("ratio test %0d done", t);
        end
        // per-stage set and reset levels, reset winning where both are held
        for (int t = 0; t < 4; t++)
        begin
            div_set_pin <= 3'($urandom);
            div_reset_pin <= (t == 3) ? 3'h2 : 3'h0;
            sq(4, 3, -1);
            {div_set_pin, div_reset_pin} <= '0;
            sq(4, 6, 2);
        end
        $display("set reset test done");
        // rises closer than the delay restart the count
        restart();
        dsync_delay <= 12'h009;
        cyc(1);
        sq(3, 10, -1);
        cyc(20);
        $display("delay restart test done");
        complete_run();
    end
endmodule : tb
